// file: rtl/ucf_defs.svh
// constants of the usb-can command packet framer
`ifndef UCF_DEFS_SVH
`define UCF_DEFS_SVH
`define UCF_APB_STATUS   8'h00
`define UCF_APB_CTRL     8'h04
`define UCF_APB_BUFSTAT  8'h08
`define UCF_APB_TICK     8'h0C
`define UCF_REQ_HDR0     8'h55
`define UCF_REQ_HDR1     8'hAA
`define UCF_RSP_HDR0     8'h66
`define UCF_RSP_HDR1     8'hBB
`define UCF_VERSION      8'h01
`define UCF_PKT_MAX      7'd64
`define UCF_REQ_DATA_MAX 8'd53
`define UCF_RSP_DATA_MAX 8'd57
`define UCF_DATA_OFS     7'd6
`define UCF_CMD_SYS      8'h20
`define UCF_CMD_FILT     8'h22
`define UCF_CMD_TX       8'h23
`define UCF_CMD_BITMOD   8'h25
`define UCF_CMD_BUFRD    8'h26
`define UCF_SUB_INFO     8'h01
`define UCF_SUB_TICK     8'h02
`define UCF_SUB_LED      8'h03
`define UCF_SUB_RATE     8'h04
`define UCF_SUB_CRESET   8'h85
`define UCF_ERR_OK       8'h00
`define UCF_ERR_HDR      8'h01
`define UCF_ERR_LEN      8'h02
`define UCF_ERR_SUM      8'h03
`define UCF_ERR_CMD      8'h04
`define UCF_EP_RSP       4'd1
`define UCF_EP_REQ       4'd2
`define UCF_EP_STAT      4'd3
`define UCF_EP_FMB       4'd4
`define UCF_STAT_LEN     4'd8
`define UCF_TICK_NS      100000
`define UCF_CLK_NS       50
`define UCF_TICK_CYC     (`UCF_TICK_NS / `UCF_CLK_NS)
`define UCF_VER_MAJOR    8'h01
`define UCF_VER_MINOR    8'h00
`endif

// file: rtl/ucf_framer.sv
// packet layer: request parse, response build, status endpoint and message buffer
`include "ucf_defs.svh"
// Notes on behaviour
// R1: responses leave on bulk-in endpoint 1
// R2: requests arrive on bulk-out endpoint 2
// R3: status packet readable anytime on endpoint 3
// R4: status packet eight bytes, 4-7 reserved
// R5: message buffer readable on endpoint 4; here it is read on bufRdAddr/bufRdData with no endpoint decode
// R6: status byte 0 is quick status
// R7: byte 1 bits 7:6 receive buffer contents
// R8: byte 1 bits 4:3 frame type
// R9: byte 1 bits 2:0 filter match
// R10: status byte 2 mirrors error flags
// R11: overwrite count of slot 2 increments
// R12: byte 3 low bits show slot occupancy
// R13: packets never exceed 64 bytes
// R14: request header 55 AA 01
// R15: command at 4, zero error at 5
// R16: length at 3, data at 6, max 53
// R17: trailing two's complement checksum
// R18: response header 66 BB 01, length
// R19: echo command, error code, max 57 data
// R20: decode the five command categories
// R21: decode system service sub-commands
// R22: exactly one response per request
// R23: bad packets answered with nonzero error
module ucf_framer (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [3:0]            epNum,
  input  wire ucf_pkg::ucf_byte_t    outByte,
  output logic                       outReady,
  input  wire logic                  inReq,
  output ucf_pkg::ucf_byte_t         inByte,
  output ucf_pkg::ucf_byte_t         statByte,
  input  wire logic                  statReq,
  input  wire logic [5:0]            bufRdAddr,
  output logic      [7:0]            bufRdData,
  input  wire logic                  bufWe,
  input  wire logic [5:0]            bufWrAddr,
  input  wire logic [7:0]            bufWrData,
  input  wire logic [2:0]            slotWrite,
  input  wire logic [2:0]            slotRead,
  input  wire ucf_pkg::ucf_ctrl_stat_t ctrlStat,
  output logic                       ledOn,
  output logic      [7:0]            bitRate,
  output logic                       ctrlResetPulse,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr
);
  import ucf_pkg::*;

  ucf_state_s_t s_q;
  ucf_state_s_t s_d;
  logic [7:0] b;
  logic [7:0] rspByte;
  logic [7:0] statSel;
  logic [2:0] statNext;
  logic       apbAcc;
  logic       apbHit;
  logic       inPop;

  // ----------------------------------------
  // received-message buffer
  // ----------------------------------------
  ucf_msg_mem u_mem (
    .clk   (clk),
    .we    (bufWe),
    .waddr (bufWrAddr),
    .wdata (bufWrData),
    .raddr (bufRdAddr),
    .rdata (bufRdData) // R5
  );

  assign b        = outByte.data;
  assign outReady = (s_q.st == S_IDLE) || (s_q.st == S_RECV); // R2
  assign inPop    = (s_q.st == S_SEND) && inReq && (epNum == `UCF_EP_RSP) && !s_q.outValid; // R1
  assign apbAcc   = psel && penable;
  assign apbHit   = (paddr == `UCF_APB_STATUS) || (paddr == `UCF_APB_CTRL) ||
                    (paddr == `UCF_APB_BUFSTAT) || (paddr == `UCF_APB_TICK);
  assign pready   = 1'b1;
  assign pslverr  = apbAcc && !apbHit;
  assign prdata   = s_q.prdata;
  assign inByte.data  = s_q.outData;
  assign inByte.valid = s_q.outValid;
  assign inByte.last  = s_q.outValid && (s_q.sendIdx == 7'(s_q.rspLen + 8'd6)); // R17
  assign statByte.data  = s_q.statData;
  assign statByte.valid = s_q.statValid;
  assign statByte.last  = s_q.statValid && (s_q.statIdx == 3'd0);
  // index of the byte loaded at the next edge; idle loads byte 0
  assign statNext       = s_q.statValid ? s_q.statIdx + 3'd1 : 3'd0;
  assign ledOn          = s_q.ledOn && s_q.ledApb;
  assign bitRate        = s_q.rate;
  assign ctrlResetPulse = s_q.ctrlReset;

  // ----------------------------------------
  // response byte at the current send index
  // ----------------------------------------
  always_comb begin
    rspByte = 8'h00;
    case (s_q.sendIdx)
      7'd0: rspByte = `UCF_RSP_HDR0; // R18
      7'd1: rspByte = `UCF_RSP_HDR1; // R18
      7'd2: rspByte = `UCF_VERSION;  // R18
      7'd3: rspByte = s_q.rspLen;    // R18
      7'd4: rspByte = s_q.cmd;       // R19
      7'd5: rspByte = s_q.err;       // R19
      default: begin
        if (s_q.sendIdx == 7'(s_q.rspLen + 8'd6)) begin
          rspByte = 8'h00 - s_q.rspSum; // R17
        end else if (s_q.cmd == `UCF_CMD_SYS && s_q.sub == `UCF_SUB_INFO) begin
          case (s_q.sendIdx)
            7'd6:  rspByte = 8'h06;
            7'd7:  rspByte = 8'h00; // vendor/product values arbitrary
            7'd8:  rspByte = 8'h00;
            7'd9:  rspByte = 8'h00;
            7'd10: rspByte = 8'h00;
            7'd11: rspByte = `UCF_VER_MAJOR;
            default: rspByte = `UCF_VER_MINOR;
          endcase
        end else if (s_q.cmd == `UCF_CMD_SYS && s_q.sub == `UCF_SUB_TICK) begin
          case (s_q.sendIdx)
            7'd6:  rspByte = 8'h05;
            7'd7:  rspByte = s_q.tick[7:0];
            7'd8:  rspByte = s_q.tick[15:8];
            7'd9:  rspByte = s_q.tick[23:16];
            default: rspByte = s_q.tick[31:24];
          endcase
        end else begin
          rspByte = 8'h01;
        end
      end
    endcase
  end

  // ----------------------------------------
  // status packet byte selection
  // ----------------------------------------
  always_comb begin
    statSel = 8'h00; // R4
    case (statNext)
      3'd0: statSel = ctrlStat.quick;    // R6
      3'd1: statSel = ctrlStat.rxStat;   // R7 R8 R9
      3'd2: statSel = ctrlStat.errFlags; // R10
      3'd3: statSel = {s_q.ovwCnt, s_q.occ}; // R11 R12
      default: statSel = 8'h00;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ctrlReset = 1'b0;
    s_d.tickDiv = s_q.tickDiv + 13'd1;
    if (s_q.tickDiv == 13'(`UCF_TICK_CYC - 1)) begin
      s_d.tickDiv = 13'd0;
      s_d.tick = s_q.tick + 32'd1;
    end
    // slot bookkeeping; a write in the same cycle as a read wins
    for (int i = 0; i < 3; i++) begin
      if (slotWrite[i]) begin
        s_d.occ[i] = 1'b1; // R12
      end else if (slotRead[i]) begin
        s_d.occ[i] = 1'b0;
      end
    end
    if (slotWrite[2] && s_q.occ[2] && !slotRead[2]) begin
      s_d.ovwCnt = s_q.ovwCnt + 5'd1; // R11
    end
    // status endpoint serialiser, answered from any state
    if (s_q.statValid) begin
      s_d.statIdx = s_q.statIdx + 3'd1;
      s_d.statValid = (s_q.statIdx != 3'd7); // R4
      s_d.statData = statSel;
    end else if (statReq && epNum == `UCF_EP_STAT) begin
      s_d.statValid = 1'b1; // R3
      s_d.statIdx = 3'd0;
      s_d.statData = statSel;
    end
    s_d.outValid = 1'b0;
    case (s_q.st)
      S_IDLE: begin
        if (outByte.valid && epNum == `UCF_EP_REQ) begin
          s_d.st = S_RECV; // R2
          s_d.cnt = 7'd1;
          s_d.sum = b;
          s_d.err = (b == `UCF_REQ_HDR0) ? `UCF_ERR_OK : `UCF_ERR_HDR; // R14
          s_d.cmd = 8'h00;
          s_d.reqLen = 7'd0;
          if (outByte.last) begin
            s_d.st = S_EXEC;
            s_d.err = `UCF_ERR_LEN;
          end
        end
      end
      S_RECV: begin
        if (outByte.valid) begin
          s_d.cnt = s_q.cnt + 7'd1;
          s_d.sum = s_q.sum + b;
          if (s_q.err == `UCF_ERR_OK) begin
            if (s_q.cnt == 7'd1 && b != `UCF_REQ_HDR1) s_d.err = `UCF_ERR_HDR; // R14
            if (s_q.cnt == 7'd2 && b != `UCF_VERSION) s_d.err = `UCF_ERR_HDR; // R14
            if (s_q.cnt == 7'd3) begin
              s_d.reqLen = 7'(b); // R16
              if (b > `UCF_REQ_DATA_MAX) s_d.err = `UCF_ERR_LEN; // R16
            end
            if (s_q.cnt == 7'd5 && b != 8'h00) s_d.err = `UCF_ERR_HDR; // R15
            if (s_q.cnt == `UCF_PKT_MAX - 7'd1 && !outByte.last) s_d.err = `UCF_ERR_LEN; // R13
          end
          if (s_q.cnt == 7'd4) s_d.cmd = b; // R15
          if (s_q.cnt == `UCF_DATA_OFS) s_d.sub = b; // R16
          if (s_q.cnt == `UCF_DATA_OFS + 7'd1) s_d.arg = b;
          if (outByte.last) begin
            s_d.st = S_EXEC;
            if (s_q.err == `UCF_ERR_OK) begin
              if (s_q.cnt != s_q.reqLen + 7'd6 || s_q.cnt < 7'd6) begin
                s_d.err = `UCF_ERR_LEN; // R23
              end else if ((s_q.sum + b) != 8'h00) begin
                s_d.err = `UCF_ERR_SUM; // R17 R23
              end
            end
          end
        end
      end
      S_EXEC: begin
        s_d.st = S_SEND; // R22
        s_d.sendIdx = 7'd0;
        s_d.rspLen = 8'd0;
        if (s_q.err == `UCF_ERR_OK) begin
          if (s_q.cmd == `UCF_CMD_SYS) begin // R20
            if (s_q.sub == `UCF_SUB_INFO) begin // R21
              s_d.rspLen = 8'd7;
            end else if (s_q.sub == `UCF_SUB_TICK) begin
              s_d.rspLen = 8'd5;
            end else if (s_q.sub == `UCF_SUB_LED) begin
              s_d.rspLen = 8'd1;
              s_d.ledOn = s_q.arg[0];
            end else if (s_q.sub == `UCF_SUB_RATE) begin
              s_d.rspLen = 8'd1;
              s_d.rate = s_q.arg;
            end else if (s_q.sub == `UCF_SUB_CRESET) begin
              s_d.ctrlReset = 1'b1;
            end else begin
              s_d.err = `UCF_ERR_CMD;
            end
          end else if (s_q.cmd != `UCF_CMD_FILT && s_q.cmd != `UCF_CMD_TX &&
                       s_q.cmd != `UCF_CMD_BITMOD && s_q.cmd != `UCF_CMD_BUFRD) begin
            s_d.err = `UCF_ERR_CMD; // R20 R23
          end
        end
        if (s_d.rspLen > `UCF_RSP_DATA_MAX) s_d.rspLen = `UCF_RSP_DATA_MAX; // R19
        s_d.rspSum = `UCF_RSP_HDR0 + `UCF_RSP_HDR1 + `UCF_VERSION;
      end
      S_SEND: begin
        if (inPop) begin
          s_d.outValid = 1'b1; // R1
          s_d.outData = rspByte;
          s_d.rspSum = (s_q.sendIdx < 7'(s_q.rspLen + 8'd6) && s_q.sendIdx > 7'd2) ?
                       s_q.rspSum + rspByte : s_q.rspSum;
        end
        if (s_q.outValid) begin
          if (s_q.sendIdx == 7'(s_q.rspLen + 8'd6)) begin
            s_d.st = S_IDLE; // R22
          end
          s_d.sendIdx = s_q.sendIdx + 7'd1;
        end
      end
      default: s_d.st = S_IDLE;
    endcase
    // register bus
    if (apbAcc && pwrite && paddr == `UCF_APB_CTRL) begin
      s_d.ledApb = pwdata[0];
    end
    if (psel && !penable && !pwrite) begin
      if (paddr == `UCF_APB_STATUS) begin
        s_d.prdata = {ctrlStat.errFlags, ctrlStat.rxStat, ctrlStat.quick, s_q.ovwCnt, s_q.occ}; // R3
      end else if (paddr == `UCF_APB_CTRL) begin
        s_d.prdata = {23'h0, s_q.rate, s_q.ledApb};
      end else if (paddr == `UCF_APB_BUFSTAT) begin
        s_d.prdata = {21'h0, 3'(s_q.st), s_q.ovwCnt, s_q.occ};
      end else if (paddr == `UCF_APB_TICK) begin
        s_d.prdata = s_q.tick;
      end else begin
        s_d.prdata = 32'h0000_0000;
      end
    end
    if (rst) begin
      s_d = '0;
      s_d.st = S_IDLE;
      s_d.ledOn = 1'b1;
      s_d.ledApb = 1'b1;
      s_d.rate = 8'h07;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_ovw_count: assert property (@(posedge clk) disable iff (rst)
    (slotWrite[2] && s_q.occ[2] && !slotRead[2]) |=> (s_q.ovwCnt == $past(s_q.ovwCnt) + 5'd1)) // R11
    else $error("overwrite count did not step");
  a_occ_set: assert property (@(posedge clk) disable iff (rst)
    slotWrite[0] |=> s_q.occ[0]) // R12
    else $error("slot 0 not marked occupied");
  a_rsp_hdr: assert property (@(posedge clk) disable iff (rst)
    (inByte.valid && s_q.sendIdx == 7'd0) |-> inByte.data == `UCF_RSP_HDR0) // R18
    else $error("response header wrong");
  a_stat_len: assert property (@(posedge clk) disable iff (rst)
    (statReq && epNum == `UCF_EP_STAT && !statByte.valid) |=> statByte.valid [*8] ##1 !statByte.valid) // R4
    else $error("status packet not eight bytes");
  a_stat_rsvd: assert property (@(posedge clk) disable iff (rst)
    (statByte.valid && s_q.statIdx > 3'd3) |-> statByte.data == 8'h00) // R4
    else $error("reserved status byte nonzero");
  a_bad_hdr: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == S_IDLE && outByte.valid && epNum == `UCF_EP_REQ && b != `UCF_REQ_HDR0)
      |=> s_q.err != `UCF_ERR_OK) // R23
    else $error("bad header not flagged");
  a_exec_once: assert property (@(posedge clk) disable iff (rst)
    s_q.st == S_EXEC |=> s_q.st == S_SEND) // R22
    else $error("request not answered");
  a_no_accept: assert property (@(posedge clk) disable iff (rst)
    (s_q.st == S_SEND) |-> !outReady) // R2
    else $error("request accepted during response");
  a_rsp_echo: assert property (@(posedge clk) disable iff (rst)
    (inByte.valid && s_q.sendIdx == 7'd4) |-> inByte.data == s_q.cmd) // R19
    else $error("command not echoed");
  a_rsp_last: assert property (@(posedge clk) disable iff (rst)
    (inByte.valid && inByte.last) |=> s_q.st == S_IDLE) // R22
    else $error("response did not end on its checksum byte");
  a_stat_first: assert property (@(posedge clk) disable iff (rst)
    (statReq && epNum == `UCF_EP_STAT && !statByte.valid) |=> statByte.data == $past(ctrlStat.quick)) // R6
    else $error("status byte 0 not the quick status");
  c_request: cover property (@(posedge clk) s_q.st == S_EXEC && s_q.err == `UCF_ERR_OK);
  c_bad_sum: cover property (@(posedge clk) s_q.st == S_EXEC && s_q.err == `UCF_ERR_SUM);
  c_status: cover property (@(posedge clk) statByte.last);
  c_ovw: cover property (@(posedge clk) s_q.ovwCnt == 5'd2);
endmodule

// file: rtl/ucf_msg_mem.sv
// small byte memory holding the received-message buffer
module ucf_msg_mem (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [5:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [5:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:63];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: rtl/ucf_pkg.sv
// types of the usb-can command packet framer
package ucf_pkg;
  typedef enum logic [2:0] {S_IDLE, S_RECV, S_EXEC, S_SEND} ucf_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       last;
  } ucf_byte_t;
  typedef struct packed {
    logic [7:0] quick;
    logic [7:0] rxStat;
    logic [7:0] errFlags;
  } ucf_ctrl_stat_t;
  typedef struct packed {
    ucf_state_t  st;
    logic [6:0]  cnt;
    logic [6:0]  reqLen;
    logic [7:0]  sum;
    logic [7:0]  cmd;
    logic [7:0]  sub;
    logic [7:0]  arg;
    logic [7:0]  err;
    logic [7:0]  rspLen;
    logic [6:0]  sendIdx;
    logic [7:0]  rspSum;
    logic [7:0]  outData;
    logic        outValid;
    logic [2:0]  statIdx;
    logic [7:0]  statData;
    logic        statValid;
    logic [4:0]  ovwCnt;
    logic [2:0]  occ;
    logic        ledOn;
    logic [7:0]  rate;
    logic        ctrlReset;
    logic [31:0] tick;
    logic [12:0] tickDiv;
    logic [31:0] prdata;
    logic        ledApb;
  } ucf_state_s_t;
endpackage

// file: verification/ucf_framer_tb.sv
// self-checking bench of the usb-can command packet framer
module ucf_framer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ucf_pkg::*;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic [3:0]     epNum;
  ucf_byte_t      outByte, inByte, statByte;
  logic           outReady, inReq, statReq, ledOn, ctrlResetPulse, pready, pslverr, perr;
  logic [5:0]     bufRdAddr = 6'h00, bufWrAddr = 6'h00;
  logic [7:0]     bufRdData, bitRate, bufWrData = 8'h00, paddr = 8'h00;
  logic           bufWe = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sawPulse = 1'b0;
  logic [2:0]     slotWrite = 3'h0, slotRead = 3'h0;
  ucf_ctrl_stat_t ctrlStat = '0;
  logic [31:0]    pwdata = 32'h0, prdata, rd;
  int             mismatches = 0, num_checks = 0, cyc = 0;
  logic [7:0]     subs [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h85};
  logic [7:0]     lens [5] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h01};
  logic [7:0]     args [5] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [7:0]     cmds [5] = '{8'h22, 8'h23, 8'h25, 8'h26, 8'h30};
  logic [7:0]     errs [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
  ucf_framer dut (.clk, .rst, .epNum, .outByte, .outReady, .inReq, .inByte, .statByte, .statReq,
    .bufRdAddr, .bufRdData, .bufWe, .bufWrAddr, .bufWrData, .slotWrite, .slotRead, .ctrlStat,
    .ledOn, .bitRate, .ctrlResetPulse, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  ucf_host_model host (.clk, .epNum, .outByte, .outReady, .inReq, .inByte, .statReq, .statByte);
  always #25 clk = ~clk;
  always @(posedge clk) if (ctrlResetPulse === 1'b1) sawPulse <= 1'b1;
  // ----
  // helpers
  // ----
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (k = 0; pready !== 1'b1 && k < 50; k++) @(posedge clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rsp_chk(input logic [7:0] cmd, input logic [7:0] err);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < host.rspN; i++) s += host.rsp[i];
    chk("rsp hdr", {host.rsp[0], host.rsp[1], host.rsp[2]}, 24'h66BB01);
    chk("rsp cmd", host.rsp[4], cmd);
    chk("rsp err", host.rsp[5], err);
    chk("rsp sum", s, 8'h00);
    chk("rsp len", host.rspN, host.rsp[3] + 8'h07);
    chk("rsp dmax", host.rsp[3] <= 8'h39, 1'b1);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk("ctrl reset", rd, 32'h0000000F);
    apb(1'b1, 8'h04, 32'h000001FE);
    apb(1'b0, 8'h04, 32'h0);
    chk("ctrl rate ro", rd, 32'h0000000E);
    apb(1'b1, 8'h04, 32'h00000001);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", perr, 1'b1);
    ctrlStat <= '{8'hA5, 8'hDE, 8'h3C};
    slotWrite <= 3'h7;
    @(posedge clk);
    slotWrite <= 3'h4;
    @(posedge clk);
    slotWrite <= 3'h0;
    slotRead <= 3'h2;
    @(posedge clk);
    slotRead <= 3'h0;
    host.status();
    chk("stat count", host.statN, 8);
    chk("stat quick", host.stat[0], 8'hA5);
    chk("stat rx", host.stat[1], 8'hDE);
    chk("stat err", host.stat[2], 8'h3C);
    chk("stat buf", host.stat[3], 8'h0D);
    apb(1'b0, 8'h00, 32'h0);
    chk("stat reg", rd, 32'h3CDEA50D);
    apb(1'b0, 8'h08, 32'h0);
    chk("buf reg", rd, 32'h0000000D);
    bufWe <= 1'b1;
    bufWrAddr <= 6'h05;
    bufWrData <= 8'h5A;
    @(posedge clk);
    bufWe <= 1'b0;
    bufRdAddr <= 6'h05;
    repeat (2) @(posedge clk);
    chk("buf read", bufRdData, 8'h5A);
    for (int i = 0; i < 5; i++) begin
      host.send(8'h20, lens[i], subs[i], args[i], 0);
      host.get();
      rsp_chk(8'h20, 8'h00);
    end
    chk("led off", ledOn, 1'b0);
    chk("rate set", bitRate, 8'h03);
    chk("ctrl reset pulse", sawPulse, 1'b1);
    for (int i = 0; i < 5; i++) begin
      host.send(cmds[i], 8'h01, 8'h00, 8'h00, 0);
      host.get();
      rsp_chk(cmds[i], errs[i]);
    end
    host.send(8'h20, 8'h02, 8'h03, 8'h01, 2);
    host.get();
    rsp_chk(8'h20, 8'h03);
    chk("led kept", ledOn, 1'b0);
    host.send(8'h20, 8'h01, 8'h01, 8'h00, 1);
    host.get();
    rsp_chk(8'h20, 8'h01);
    host.send(8'h20, 8'h36, 8'h01, 8'h00, 0);
    host.get();
    rsp_chk(8'h20, 8'h02);
    host.send(8'h20, 8'h02, 8'h03, 8'h01, 0);
    host.get();
    rsp_chk(8'h20, 8'h00);
    chk("led on", ledOn, 1'b1);
    report_and_stop();
  end
endmodule

// file: verification/ucf_host_model.sv
// host application model: sends requests, fetches responses and status
module ucf_host_model (
  input  wire logic               clk,
  output logic [3:0]              epNum,
  output ucf_pkg::ucf_byte_t      outByte,
  input  wire logic               outReady,
  output logic                    inReq,
  input  wire ucf_pkg::ucf_byte_t inByte,
  output logic                    statReq,
  input  wire ucf_pkg::ucf_byte_t statByte
);
  timeunit 1ns;
  timeprecision 100ps;
  import ucf_pkg::*;
  logic [7:0] rsp [64];
  logic [7:0] stat [8];
  int         rspN;
  int         statN;
  initial begin
    epNum = 4'h0;
    outByte = '0;
    inReq = 1'b0;
    statReq = 1'b0;
  end
  // ----
  // request out; kind 1 spoils the header, kind 2 the checksum
  // ----
  task automatic send(input logic [7:0] cmd, input logic [7:0] n, input logic [7:0] d0,
                      input logic [7:0] d1, input int kind);
    logic [7:0] p [64];
    logic [7:0] s;
    int len;
    int k;
    len = 7 + n;
    for (int i = 0; i < 64; i++) p[i] = 8'h00;
    p[0] = (kind == 1) ? 8'h56 : 8'h55;
    p[1] = 8'hAA;
    p[2] = 8'h01;
    p[3] = n;
    p[4] = cmd;
    p[5] = 8'h00;
    p[6] = d0;
    if (n > 1) p[7] = d1;
    s = 8'h00;
    for (int i = 0; i < len - 1; i++) s += p[i];
    p[len-1] = (kind == 2) ? 8'h01 - s : 8'h00 - s;
    k = 0;
    while (outReady !== 1'b1 && k < 200) begin
      k++;
      @(posedge clk);
    end
    epNum <= 4'h2;
    for (int i = 0; i < len; i++) begin
      outByte <= '{p[i], 1'b1, i == len - 1};
      @(posedge clk);
    end
    // released line shows the inverse, not a stale byte
    outByte <= '{~p[len-1], 1'b0, 1'b0};
  endtask
  // ----
  // response and status fetch
  // ----
  task automatic get();
    int k;
    rspN = 0;
    k = 0;
    epNum <= 4'h1;
    inReq <= 1'b1;
    while (k < 400) begin
      @(posedge clk);
      k++;
      if (inByte.valid === 1'b1) begin
        rsp[rspN] = inByte.data;
        rspN++;
        if (inByte.last === 1'b1 || rspN == 64) break;
      end
    end
    inReq <= 1'b0;
  endtask
  task automatic status();
    int k;
    statN = 0;
    epNum <= 4'h3;
    statReq <= 1'b1;
    @(posedge clk);
    statReq <= 1'b0;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (statByte.valid === 1'b1) begin
        if (statN < 8) stat[statN] = statByte.data;
        statN++;
      end
    end
  endtask
endmodule
